// ===== hdl/secmem_pins.sv
// Pin behaviour and user zone gating of the secure serial memory
//
// Summary of operation
// - Async bits last 372 carrier periods each
// - Sample on clock rise, change on fall
// - Data line only driven low, else released
// - Async reset release sends 64-bit answer
// - Reset pin low clears answer, line drive, zone and config rights; not mode flag
// - Reset pin idles high when unconnected
// - No answer-to-reset in synchronous mode
// - User memory has 4, 8 or 16 zones
// - Zone access refused until security met
// - Configuration access needs secure code first
// - Blown fuses lock configuration against writes
// - Small variants use 16-byte pages
// - Two-kilobit: four 64-byte zones, rows to 38h
// - Eight-zone: eight 128-byte zones, rows to 78h
// - Larger variants use 64 or 128-byte pages
`timescale 1ns/1ns
module secmem_pins
    import secmem_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    // Host-facing pins
    input wire logic scl_clk_in,
    input wire logic rst_pin_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // Mode and answer-to-reset content
    input wire logic async_set_in,
    input wire logic [ATR_BITS-1:0] atr_value_in,
    // Synchronous bit stream towards the protocol engine
    input wire logic tx_en_in,
    input wire logic tx_bit_in,
    output logic rx_bit_out,
    output logic rx_valid_out,
    output logic fall_out,
    // Zone selection and access
    input wire density_t density_in,
    input wire logic zone_sel_in,
    input wire logic [3:0] zone_in,
    input wire logic access_req_in,
    input wire logic [ADDR_W-1:0] row_in,
    input wire logic [COL_W-1:0] col_in,
    input wire logic [15:0] zone_grant_in,
    output logic access_ok_out,
    output logic access_err_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic [7:0] page_bytes_out,
    output logic [4:0] zone_count_out,
    // Configuration memory gating
    input wire logic secure_code_ok_in,
    input wire logic fuse_blown_in,
    output logic config_read_ok_out,
    output logic config_write_ok_out,
    output logic async_mode_out
);

    // Filtered pin levels
    logic [2:0] pins_s;
    logic scl_prev_q;
    logic rst_prev_q;
    logic scl_rise;
    logic scl_fall;
    logic pin_rst_n;
    logic rst_release;

    // Sampler; reset pin idles high like the pad pull-up
    pin_sampler #(.W(3), .IDLE(PIN_IDLE)) u_sampler (
        .clock_in(clock_in),
        .rst_n_in(rst_n_in),
        .pin_in({sda_in, rst_pin_in, scl_clk_in}),
        .level_out(pins_s)
    );

    assign pin_rst_n = pins_s[PIN_RST];
    assign scl_rise = pins_s[PIN_SCL] & ~scl_prev_q;
    assign scl_fall = ~pins_s[PIN_SCL] & scl_prev_q;
    assign rst_release = pin_rst_n & ~rst_prev_q;

    // Edge history of clock and reset pins
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scl_prev_q <= 1'b0;
            rst_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= pins_s[PIN_SCL];
            rst_prev_q <= pin_rst_n;
        end
    end

    // Mode flag survives the reset pin, only the chip reset clears it
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            async_mode_out <= 1'b0;
        end else if (async_set_in) begin
            async_mode_out <= 1'b1;
        end
    end

    // Answer-to-reset sequencer state
    atr_state_t atr_state_q;
    logic [8:0] etu_cnt_q; // Carrier periods within the current bit
    logic [5:0] atr_idx_q; // Bit being sent, LSB first
    logic atr_bit;

    assign atr_bit = atr_value_in[atr_idx_q];

    // Sequencer: starts on reset release in async mode only
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            atr_state_q <= ATR_IDLE;
            etu_cnt_q <= '0;
            atr_idx_q <= '0;
        end else if (!pin_rst_n) begin
            // Pin reset clears the sequence
            atr_state_q <= ATR_IDLE;
            etu_cnt_q <= '0;
            atr_idx_q <= '0;
        end else begin
            unique case (atr_state_q)
                ATR_IDLE: begin
                    // Sync mode never answers
                    if (rst_release && async_mode_out) begin
                        atr_state_q <= ATR_SEND;
                    end
                end
                ATR_SEND: begin
                    // Carrier counted on the filtered clock pin
                    if (scl_rise) begin
                        if (etu_cnt_q == ETU_LAST) begin
                            etu_cnt_q <= '0;
                            if (atr_idx_q == ATR_LAST) begin
                                atr_state_q <= ATR_DONE;
                            end else begin
                                atr_idx_q <= atr_idx_q + 6'h01;
                            end
                        end else begin
                            etu_cnt_q <= etu_cnt_q + 9'h001;
                        end
                    end
                end
                ATR_DONE: begin
                    // Stays done until the next pin reset
                    atr_state_q <= ATR_DONE;
                end
                default: begin
                    atr_state_q <= ATR_IDLE;
                end
            endcase
        end
    end

    // Data pin: output level is always low, only the enable moves
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sda_out <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (!pin_rst_n) begin
            sda_out <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (atr_state_q == ATR_SEND) begin
            // Pull low for a zero bit, release for a one
            sda_out <= 1'b0;
            sda_oe_out <= ~atr_bit;
        end else if (!async_mode_out && scl_fall) begin
            // Outgoing data changes on the falling edge
            sda_out <= 1'b0;
            sda_oe_out <= tx_en_in & ~tx_bit_in;
        end else if (async_mode_out) begin
            sda_out <= 1'b0;
            sda_oe_out <= 1'b0;
        end
    end

    // Incoming data taken on the rising edge in sync mode
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rx_bit_out <= 1'b1;
            rx_valid_out <= 1'b0;
            fall_out <= 1'b0;
        end else begin
            rx_valid_out <= pin_rst_n & ~async_mode_out & scl_rise;
            fall_out <= pin_rst_n & ~async_mode_out & scl_fall;
            if (scl_rise) begin
                rx_bit_out <= pins_s[PIN_SDA];
            end
        end
    end

    // Density table: zone size, page size, zone count
    logic [11:0] zone_bytes;
    always_comb begin
        zone_bytes = ZONE_128;
        unique case (density_in)
            DENS_1K: zone_bytes = ZONE_32;
            DENS_2K: zone_bytes = ZONE_64;
            DENS_4K, DENS_8K, DENS_16K: zone_bytes = ZONE_128;
            DENS_32K: zone_bytes = ZONE_256;
            DENS_64K: zone_bytes = ZONE_512;
            DENS_128K: zone_bytes = ZONE_1024;
            DENS_256K: zone_bytes = ZONE_2048;
            default: zone_bytes = ZONE_128;
        endcase
    end

    // Page size and zone count are static per variant
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            page_bytes_out <= PAGE_16;
            zone_count_out <= ZONES_4;
        end else begin
            unique case (density_in)
                DENS_1K, DENS_2K, DENS_4K: begin
                    page_bytes_out <= PAGE_16;
                    zone_count_out <= ZONES_4;
                end
                DENS_8K: begin
                    page_bytes_out <= PAGE_16;
                    zone_count_out <= ZONES_8;
                end
                DENS_16K: begin
                    page_bytes_out <= PAGE_16;
                    zone_count_out <= ZONES_16;
                end
                DENS_32K, DENS_64K: begin
                    page_bytes_out <= PAGE_64;
                    zone_count_out <= ZONES_16;
                end
                DENS_128K, DENS_256K: begin
                    page_bytes_out <= PAGE_128;
                    zone_count_out <= ZONES_16;
                end
                default: begin
                    page_bytes_out <= PAGE_16;
                    zone_count_out <= ZONES_4;
                end
            endcase
        end
    end

    // Selected zone; lost on pin reset like any granted right
    logic [3:0] zone_q;
    logic zone_valid_q;
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            zone_q <= 4'h0;
            zone_valid_q <= 1'b0;
        end else if (!pin_rst_n) begin
            zone_valid_q <= 1'b0;
        end else if (zone_sel_in) begin
            zone_q <= zone_in;
            zone_valid_q <= 1'b1;
        end
    end

    // Access check terms
    logic in_range;
    logic row_aligned;
    logic zone_exists;
    assign zone_exists = {1'b0, zone_q} < zone_count_out;
    assign row_aligned = (row_in[COL_W-1:0] == 3'h0);
    assign in_range = {1'b0, row_in} < zone_bytes;

    // Access result: one-cycle pulse per request
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            access_ok_out <= 1'b0;
            access_err_out <= 1'b0;
            addr_out <= ADDR_ZERO;
        end else if (!pin_rst_n) begin
            access_ok_out <= 1'b0;
            access_err_out <= 1'b0;
        end else begin
            access_ok_out <= 1'b0;
            access_err_out <= 1'b0;
            if (access_req_in) begin
                // Unselected or unsecured zones are refused
                if (zone_valid_q && zone_exists && zone_grant_in[zone_q] && row_aligned && in_range) begin
                    access_ok_out <= 1'b1;
                    addr_out <= row_in + {8'h00, col_in};
                end else begin
                    access_err_out <= 1'b1;
                end
            end
        end
    end

    // Configuration gate: secure code unlocks, fuses freeze writes
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            config_read_ok_out <= 1'b0;
            config_write_ok_out <= 1'b0;
        end else if (!pin_rst_n) begin
            config_read_ok_out <= 1'b0;
            config_write_ok_out <= 1'b0;
        end else begin
            if (secure_code_ok_in) begin
                config_read_ok_out <= 1'b1;
            end
            // Fuse state wins even after unlock
            config_write_ok_out <= (config_read_ok_out | secure_code_ok_in) & ~fuse_blown_in;
        end
    end

endmodule

// ===== hdl/secmem_pkg.sv
// Shared constants and types for the secure memory pin and zone logic
package secmem_pkg;

    // Carrier periods per elementary time unit in the asynchronous mode
    localparam int unsigned ETU_CARRIERS = 372;
    localparam logic [8:0] ETU_LAST = 9'(ETU_CARRIERS - 1);

    // Answer-to-reset register length in bits
    localparam int unsigned ATR_BITS = 64;
    localparam logic [5:0] ATR_LAST = 6'(ATR_BITS - 1);

    // System clock, for reference by the bench
    localparam int unsigned CLOCK_HZ = 20000000;

    // Pin sampler lanes and their idle levels
    localparam int unsigned PIN_SCL = 0;
    localparam int unsigned PIN_RST = 1;
    localparam int unsigned PIN_SDA = 2;
    localparam logic [2:0] PIN_IDLE = 3'h6;

    // Zone addressing widths
    localparam int unsigned ADDR_W = 11;
    localparam int unsigned COL_W = 3;
    localparam logic [ADDR_W-1:0] ADDR_ZERO = 11'h000;

    // Density variants, smallest first
    typedef enum logic [3:0] {
        DENS_1K = 4'h0,
        DENS_2K = 4'h1,
        DENS_4K = 4'h2,
        DENS_8K = 4'h3,
        DENS_16K = 4'h4,
        DENS_32K = 4'h5,
        DENS_64K = 4'h6,
        DENS_128K = 4'h7,
        DENS_256K = 4'h8
    } density_t;

    // Asynchronous answer-to-reset sequencer states
    typedef enum logic [1:0] {
        ATR_IDLE = 2'b00,
        ATR_SEND = 2'b01,
        ATR_DONE = 2'b10
    } atr_state_t;

    // Zone sizes, page sizes and zone counts
    localparam logic [11:0] ZONE_32 = 12'h020;
    localparam logic [11:0] ZONE_64 = 12'h040;
    localparam logic [11:0] ZONE_128 = 12'h080;
    localparam logic [11:0] ZONE_256 = 12'h100;
    localparam logic [11:0] ZONE_512 = 12'h200;
    localparam logic [11:0] ZONE_1024 = 12'h400;
    localparam logic [11:0] ZONE_2048 = 12'h800;
    localparam logic [7:0] PAGE_16 = 8'h10;
    localparam logic [7:0] PAGE_64 = 8'h40;
    localparam logic [7:0] PAGE_128 = 8'h80;
    localparam logic [4:0] ZONES_4 = 5'h04;
    localparam logic [4:0] ZONES_8 = 5'h08;
    localparam logic [4:0] ZONES_16 = 5'h10;

endpackage

// ===== hdl/pin_sampler.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sampler #(
    parameter int unsigned W = 3,
    parameter logic [W-1:0] IDLE = '0
) (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);

    // Stage registers; the first is read only by the second
    logic [W-1:0] meta_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // Shift chain
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_q <= IDLE;
            s2_q <= IDLE;
            s3_q <= IDLE;
        end else begin
            meta_q <= pin_in;
            s2_q <= meta_q;
            s3_q <= s2_q;
        end
    end

    // A change is taken only when stages two and three agree
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_lane
            always_ff @(posedge clock_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    level_out[i] <= IDLE[i];
                end else if (s2_q[i] == s3_q[i]) begin
                    level_out[i] <= s3_q[i];
                end
            end
        end
    endgenerate

endmodule

// ===== tb/secmem_pins_props.sv
// Port assertions for the secure memory pin and zone block
`timescale 1ns/1ns
module secmem_pins_props
    import secmem_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic rst_pin_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic fall_out,
    input wire logic async_mode_out,
    input wire density_t density_in,
    input wire logic access_req_in,
    input wire logic [ADDR_W-1:0] row_in,
    input wire logic [COL_W-1:0] col_in,
    input wire logic access_ok_out,
    input wire logic access_err_out,
    input wire logic [ADDR_W-1:0] addr_out,
    input wire logic [7:0] page_bytes_out,
    input wire logic [4:0] zone_count_out,
    input wire logic secure_code_ok_in,
    input wire logic fuse_blown_in,
    input wire logic config_read_ok_out,
    input wire logic config_write_ok_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    logic [ADDR_W-1:0] addr_q; // Row plus column of the last request
    logic [2:0] pin_hi_q; // Cycles the reset pin stood high, saturating
    logic live; // Request made well clear of a pin reset, so the sampler has settled
    assign live = access_req_in && (pin_hi_q == 3'h7);
    // Request address and reset pin age
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            addr_q <= ADDR_ZERO;
            pin_hi_q <= 3'h0;
        end else begin
            if (access_req_in) begin
                addr_q <= row_in + ADDR_W'(col_in);
            end
            if (!rst_pin_in) begin // Pin reset restarts the age
                pin_hi_q <= 3'h0;
            end else if (pin_hi_q != 3'h7) begin
                pin_hi_q <= pin_hi_q + 3'h1;
            end
        end
    end
    property p_sda_low; !sda_out; endproperty
    a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
    property p_oe_cause; $rose(sda_oe_out) |-> (async_mode_out || fall_out); endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("line pulled off a fall");
    property p_answer; live |=> (access_ok_out != access_err_out); endproperty
    a_answer: assert property (p_answer) else $error("access not answered once");
    property p_align; live && (row_in[2:0] != 3'h0) |=> access_err_out; endproperty
    a_align: assert property (p_align) else $error("misaligned row accepted");
    property p_addr; access_ok_out |-> (addr_out == addr_q); endproperty
    a_addr: assert property (p_addr) else $error("address not row plus column");
    property p_small; (density_in <= DENS_4K) |=> (page_bytes_out == PAGE_16) && (zone_count_out == ZONES_4); endproperty
    a_small: assert property (p_small) else $error("small variant geometry wrong");
    property p_large;
        (density_in >= DENS_32K) |=> (page_bytes_out == (($past(density_in) >= DENS_128K) ? PAGE_128 : PAGE_64));
    endproperty
    a_large: assert property (p_large) else $error("large variant page wrong");
    property p_code; secure_code_ok_in && (pin_hi_q == 3'h7) |=> config_read_ok_out; endproperty
    a_code: assert property (p_code) else $error("config not opened by code");
    property p_fuse; fuse_blown_in [*4] |-> !config_write_ok_out; endproperty
    a_fuse: assert property (p_fuse) else $error("config writable after fuse");
    property p_flag_kept; !$fell(async_mode_out); endproperty
    a_flag_kept: assert property (p_flag_kept) else $error("mode flag lost");
    c_ok: cover property (access_ok_out);
    c_err: cover property (access_err_out);
    c_atr: cover property (async_mode_out && $rose(sda_oe_out));
endmodule
bind secmem_pins secmem_pins_props i_props (.clock_in, .rst_n_in, .rst_pin_in, .sda_out, .sda_oe_out, .fall_out,
    .async_mode_out, .density_in, .access_req_in, .row_in, .col_in, .access_ok_out, .access_err_out, .addr_out,
    .page_bytes_out, .zone_count_out, .secure_code_ok_in, .fuse_blown_in, .config_read_ok_out, .config_write_ok_out);

// ===== tb/host_model.sv
// Behavioural host: clock pin generator and open-drain data line
`timescale 1ns/1ns
module host_model #(
    parameter int HALF = 8
) (
    input wire logic clock_in,
    input wire logic run_in,
    input wire logic host_bit_in,
    input wire logic dev_oe_in,
    output logic scl_out,
    output logic sda_wire_out
);
    int half_cnt = HALF; // Cycles left in this clock phase
    logic bit_q = 1'b1; // Bit the host puts on the line, 1 releases it
    initial scl_out = 1'b0;
    // Clock pin runs only within a transfer and rests low between them
    always @(posedge clock_in) begin
        if (!run_in) begin
            scl_out <= 1'b0;
            half_cnt <= HALF;
            bit_q <= host_bit_in;
        end else if (half_cnt == 1) begin
            half_cnt <= HALF;
            scl_out <= !scl_out;
            if (scl_out) begin // New data only after a falling edge
                bit_q <= host_bit_in;
            end
        end else begin
            half_cnt <= half_cnt - 1;
        end
    end
    // Either side only pulls low; the pull-up gives a high otherwise
    assign sda_wire_out = (!bit_q || dev_oe_in) ? 1'b0 : 1'b1;
endmodule

// ===== tb/secmem_pins_test.sv
// Self-checking bench for the secure memory pin and zone block
`timescale 1ns/1ns
module secmem_pins_test
    import secmem_pkg::*;
();
    typedef struct packed {logic ok; logic [ADDR_W-1:0] addr;} answer_t; // Expected access answer
    logic clock_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic rst_pin_in = 1'b1; // Held high as if left unconnected
    logic async_set_in = 1'b0, tx_en_in = 1'b0, tx_bit_in = 1'b0, zone_sel_in = 1'b0, access_req_in = 1'b0;
    logic secure_code_ok_in = 1'b0, fuse_blown_in = 1'b0, run = 1'b0, host_bit = 1'b1, b, seen;
    logic [ATR_BITS-1:0] atr_value_in = '0;
    density_t density_in = DENS_1K;
    logic [3:0] zone_in = 4'h0;
    logic [ADDR_W-1:0] row_in = ADDR_ZERO, r;
    logic [COL_W-1:0] col_in = 3'h0;
    logic [15:0] zone_grant_in = 16'h0000;
    logic scl_clk_in, sda_in, sda_out, sda_oe_out, rx_bit_out, rx_valid_out, fall_out, async_mode_out;
    logic access_ok_out, access_err_out, config_read_ok_out, config_write_ok_out;
    logic [ADDR_W-1:0] addr_out;
    logic [7:0] page_bytes_out;
    logic [4:0] zone_count_out;
    int num_errors = 0, n_tests = 0, rises = 0, mark = 0;
    answer_t exp_q[$], ans;
    secmem_pins i_dut (.clock_in, .rst_n_in, .scl_clk_in, .rst_pin_in, .sda_in, .sda_out, .sda_oe_out,
        .async_set_in, .atr_value_in, .tx_en_in, .tx_bit_in, .rx_bit_out, .rx_valid_out, .fall_out, .density_in,
        .zone_sel_in, .zone_in, .access_req_in, .row_in, .col_in, .zone_grant_in, .access_ok_out, .access_err_out,
        .addr_out, .page_bytes_out, .zone_count_out, .secure_code_ok_in, .fuse_blown_in, .config_read_ok_out,
        .config_write_ok_out, .async_mode_out);
    host_model #(.HALF(8)) i_host (.clock_in, .run_in(run), .host_bit_in(host_bit), .dev_oe_in(sda_oe_out),
        .scl_out(scl_clk_in), .sda_wire_out(sda_in));
    // 20 MHz system clock
    initial begin
        forever #25 clock_in = !clock_in;
    end
    // Carrier periods seen on the clock pin
    always @(posedge scl_clk_in) rises <= rises + 1;
    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
        #2;
    endtask
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Bounded wait: 0 receive pulse, 1 fall pulse, 2 line drive level
    task automatic wait_until(input int which, input logic v, input int limit);
        logic got;
        for (int i = 0; i < limit; i++) begin
            got = (which == 0) ? rx_valid_out : (which == 1) ? fall_out : sda_oe_out;
            if (got === v) return;
            tick(1);
        end
        check("wait bound", 64'h0, 64'h1);
        close_out();
    endtask
    task automatic select(input logic [3:0] z);
        zone_in = z;
        zone_sel_in = 1'b1;
        tick(1);
        zone_sel_in = 1'b0;
        tick(1);
    endtask
    // Request one access and note the answer expected
    task automatic access(input logic [ADDR_W-1:0] row, input logic [COL_W-1:0] col, input logic ok);
        exp_q.push_back({ok, row + ADDR_W'(col)});
        row_in = row;
        col_in = col;
        access_req_in = 1'b1;
        tick(1);
        access_req_in = 1'b0;
        tick(1);
    endtask
    // Answer watcher, oldest note first; the falling edge sees each pulse settled, once
    always @(negedge clock_in) begin
        if (rst_n_in && (access_ok_out === 1'b1 || access_err_out === 1'b1)) begin
            if (exp_q.size() == 0) begin
                check("unexpected answer", 64'h0, 64'h1);
            end else begin
                ans = exp_q.pop_front();
                check("access ok", 64'(ans.ok), 64'(access_ok_out));
                if (ans.ok) check("access addr", 64'(ans.addr), 64'(addr_out));
            end
        end
    end
    initial begin
        void'($urandom(32'hc696));
        atr_value_in = {32'($urandom), 28'($urandom), 4'ha};
        tick(4);
        rst_n_in = 1'b1;
        tick(6);
        check("config before code", 64'h0, 64'(config_read_ok_out));
        for (int d = 0; d <= 8; d++) begin
            density_in = density_t'(d);
            tick(2);
            check("zone count", 64'(d < 3 ? 4 : d == 3 ? 8 : 16), 64'(zone_count_out));
            check("page bytes", 64'(d < 5 ? 16 : d < 7 ? 64 : 128), 64'(page_bytes_out));
        end
        $display("test densities done");
        density_in = DENS_2K;
        zone_grant_in = 16'h0002;
        access(11'h000, 3'h0, 1'b0);
        select(4'h1);
        access(11'h038, 3'h7, 1'b1);
        access(11'h040, 3'h0, 1'b0);
        access(11'h013, 3'h0, 1'b0);
        r = 11'($urandom_range(7)) << 3;
        access(r, 3'($urandom), 1'b1);
        select(4'h0);
        access(11'h000, 3'h0, 1'b0);
        density_in = DENS_8K;
        zone_grant_in = 16'($urandom) | 16'h0080;
        select(4'h7);
        access(11'h078, 3'h5, 1'b1);
        access(11'h080, 3'h0, 1'b0);
        zone_grant_in = 16'hffff;
        select(4'h8);
        access(11'h000, 3'h0, 1'b0);
        $display("test zones done");
        secure_code_ok_in = 1'b1;
        tick(1);
        secure_code_ok_in = 1'b0;
        tick(3);
        check("config read", 64'h1, 64'(config_read_ok_out));
        check("config write", 64'h1, 64'(config_write_ok_out));
        fuse_blown_in = 1'b1;
        tick(4);
        check("config locked", 64'h0, 64'(config_write_ok_out));
        $display("test config done");
        host_bit = 1'($urandom);
        tick(1);
        run = 1'b1;
        for (int k = 0; k < 8; k++) begin
            b = host_bit;
            wait_until(0, 1'b1, 200);
            check("rx bit", 64'(b), 64'(rx_bit_out));
            host_bit = 1'($urandom);
            tick(1);
        end
        host_bit = 1'b1;
        tx_en_in = 1'b1;
        for (int k = 0; k < 4; k++) begin
            b = (k < 2) ? k[0] : 1'($urandom);
            tx_bit_in = b;
            wait_until(1, 1'b1, 200);
            check("tx drive", 64'(!b), 64'(sda_oe_out));
            check("line level", 64'(b), 64'(sda_in));
            tick(1);
        end
        tx_en_in = 1'b0;
        rst_pin_in = 1'b0;
        tick(8);
        rst_pin_in = 1'b1;
        seen = 1'b0;
        for (int i = 0; i < 800; i++) begin
            tick(1);
            seen = seen | sda_oe_out;
        end
        check("answer in sync mode", 64'h0, 64'(seen));
        run = 1'b0;
        $display("test sync done");
        rst_pin_in = 1'b0;
        async_set_in = 1'b1;
        tick(1);
        async_set_in = 1'b0;
        tick(8);
        rst_pin_in = 1'b1;
        run = 1'b1;
        wait_until(2, 1'b1, 50);
        for (int k = 1; k < 4; k++) begin
            wait_until(2, !atr_value_in[k], 8000);
            if (k > 1) check("bit length", 64'(ETU_CARRIERS), 64'(rises - mark));
            mark = rises;
        end
        rst_pin_in = 1'b0;
        tick(8);
        check("line in pin reset", 64'h0, 64'(sda_oe_out));
        check("mode kept", 64'h1, 64'(async_mode_out));
        run = 1'b0;
        $display("test async done");
        check("answers left", 64'h0, 64'(exp_q.size()));
        close_out();
    end
endmodule
